// file: rtl/rx_frame_statistics_vector.sv
// rx_frame_statistics_vector: per-frame receive report for a 10 Gb/s MAC receiver.
// assumes the receive beat stream and Avalon-MM master run on clk (rx_core_clock).
// assumes ce low freezes every flop, so a strobe stretches while it is low.
// Operation
// RULE1: report driven on receive clock after frames
// RULE2: fields valid with strobe, byte count always
// RULE3: 64-bit: strobe with final beat indication
// RULE4: 32-bit: strobe one cycle after final beat
// RULE5: bit 30 priority pause, only if built
// RULE6: bit 29 length field or padding mismatch
// RULE7: bit 28 good control frame, non-pause opcode
// RULE8: bit 27 good, accepted, addressed pause frame
// RULE9: bits 26:23 bytes seen last cycle
// RULE10: bit 22 VLAN tag with VLAN enabled
// RULE11: bit 21 oversize, never with jumbo enabled
// RULE12: bit 20 length/type equals 88-08
// RULE13: bits 19:5 length, saturating at 32767
// RULE14: bit 4 multicast destination address
// RULE15: bit 3 broadcast destination address
// RULE16: bit 2 FCS or line code error
// RULE17: bit 1 frame had any error
// RULE18: bit 0 frame was error free
// RULE19: management output disable: 1 releases line
// RULE20: exactly one of good and bad flags
// RULE21: strobe lasts exactly one cycle per frame
`timescale 1ns/100ps
module rx_frame_statistics_vector #(
  parameter int DATA_W = 64,
  parameter bit PFC_EN = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [rxstat_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_in_valid,
  input wire logic [DATA_W-1:0] rx_in_data,
  input wire logic [DATA_W/8-1:0] rx_in_keep,
  input wire logic rx_in_last,
  input wire logic rx_in_line_err,
  input wire logic rx_in_fcs_bad,
  output logic rx_out_valid,
  output logic [DATA_W-1:0] rx_out_data,
  output logic [DATA_W/8-1:0] rx_out_keep,
  output logic rx_out_last,
  output logic [rxstat_pkg::VEC_W-1:0] stat_vector,
  output logic stat_valid,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_tri
);
  import rxstat_pkg::*;

  // lanes per beat; only 64 and 32 bit datapaths are meant to be built
  // narrow datapath delays the strobe one cycle behind the final beat
  localparam int KEEP_W = DATA_W / 8;
  localparam bit NARROW = (DATA_W == 32);

  // byte-enable merge of a write into an old word
  // lanes with a clear enable keep their stored bits
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // count of valid byte lanes in one beat
  // counts every set keep bit, so gaps in keep still add up
  function automatic logic [3:0] lane_count(input logic [KEEP_W-1:0] keep);
    logic [3:0] n;
    n = 4'h0;
    for (int b = 0; b < KEEP_W; b++) begin
      n = n + {3'h0, keep[b]};
    end
    return n;
  endfunction

  // bus side state
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_word;
  logic [CTRL_W-1:0] ctrl_r;
  logic [14:0] max_len_r;
  logic [47:0] own_addr_r;
  logic wr_ok;
  // management pin state
  logic mdio_meta_r;
  logic mdio_sync_r;
  logic mdio_out_r;
  logic mdio_tri_r;
  // frame tracking state
  rx_state_t st_r;
  logic [14:0] len_r;
  logic err_r;
  logic [7:0] hdr_r [HDR_BYTES];
  logic [7:0] hdr_n [HDR_BYTES];
  logic [15:0] base;
  logic [15:0] pos;
  logic [15:0] sum;
  logic [14:0] len_nxt;
  logic [3:0] cnt;
  logic err_n;
  logic beat;
  logic fin;
  // report state
  logic [VEC_W-1:0] vec_r;
  logic [VEC_W-1:0] fin_vec;
  logic valid_r;
  logic pend_r;
  // client stream stage
  logic out_valid_r;
  logic [DATA_W-1:0] out_data_r;
  logic [KEEP_W-1:0] out_keep_r;
  logic out_last_r;
  logic [15:0] frame_cnt_r;
  // classification terms
  logic [15:0] lt;
  logic [15:0] opc;
  logic [47:0] da;
  logic [14:0] data_bytes;
  logic bcast;
  logic ctl;
  logic da_ok;
  logic len_bad;
  logic oversize;
  logic fcs_bad;
  logic bad;
  logic good;
  logic [31:0] ctrl_wd;
  logic [31:0] max_len_wd;
  logic [31:0] own_lo_wd;
  logic [31:0] own_hi_wd;
  logic pad_case;
  logic len_differs;

  // write lands at the edge where waitrequest is low
  // beats are taken only while the clock enable is high
  assign wr_ok = avs_write && !wait_r;
  assign beat = ce && rx_in_valid;
  assign fin = beat && rx_in_last;
  assign cnt = lane_count(rx_in_keep);

  // write words merged with the stored value, cut to register width below
  // keeps a partial byte-lane write from clearing the untouched lanes
  assign ctrl_wd = be_merge({27'h0, ctrl_r}, avs_writedata, avs_byteenable);
  assign max_len_wd = be_merge({17'h0, max_len_r}, avs_writedata, avs_byteenable);
  assign own_lo_wd = be_merge(own_addr_r[31:0], avs_writedata, avs_byteenable);
  assign own_hi_wd = be_merge({16'h0, own_addr_r[47:32]}, avs_writedata, avs_byteenable);

  // register read multiplexer, unmapped words read zero
  // address decode is combinational, the word is registered on capture
  always_comb begin
    rd_word = 32'h0;
    case (avs_address)
      REG_CTRL: rd_word = {27'h0, ctrl_r};
      REG_MAX_LEN: rd_word = {17'h0, max_len_r};
      REG_OWN_LO: rd_word = own_addr_r[31:0];
      REG_OWN_HI: rd_word = {16'h0, own_addr_r[47:32]};
      REG_LAST_VEC: rd_word = {1'b0, vec_r};
      REG_STATUS: rd_word = {mdio_sync_r, 15'h0, frame_cnt_r};
      default: rd_word = 32'h0;
    endcase
  end

  // bus handshake: waitrequest drops for one cycle per request
  // one wait state then one ready cycle; a request still held after the ready cycle is taken again
  // read data stands until the next read is captured
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else if (ce) begin
      if (!wait_r) begin
        wait_r <= 1'b1;
      end else if (avs_read || avs_write) begin
        wait_r <= 1'b0;
      end
      // read data captured together with the request
      if (avs_read && wait_r) begin
        rdata_r <= rd_word;
      end
    end
  end

  // configuration registers, written at the accepting edge
  // unmapped words and the read-only words ignore writes
  // byte lanes merge with the stored value, so partial writes are safe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RESET;
      max_len_r <= MAX_LEN_RESET;
      own_addr_r <= OWN_ADDR_RESET;
    end else if (ce && wr_ok) begin
      case (avs_address)
        REG_CTRL: ctrl_r <= ctrl_wd[CTRL_W-1:0];
        REG_MAX_LEN: max_len_r <= max_len_wd[14:0];
        REG_OWN_LO: own_addr_r[31:0] <= own_lo_wd;
        REG_OWN_HI: own_addr_r[47:32] <= own_hi_wd[15:0];
        default: ;
      endcase
    end
  end

  // management data pin: two-stage input sync, registered drive
  // pin input settles through two flops before status can read it
  // drive and release follow the control bits one cycle later
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mdio_meta_r <= 1'b1;
      mdio_sync_r <= 1'b1;
      mdio_out_r <= 1'b1;
      mdio_tri_r <= 1'b1;
    end else if (ce) begin
      mdio_meta_r <= mdio_in;
      mdio_sync_r <= mdio_meta_r;
      mdio_out_r <= ctrl_r[CTRL_MDIO_VAL];
      mdio_tri_r <= ~ctrl_r[CTRL_MDIO_DRV]; // [RULE19]
    end
  end

  // running length and header capture including the current beat
  // sum is one bit wider than the length so saturation is seen
  // header bytes beyond the first sixteen are not kept
  always_comb begin
    base = (st_r == ST_FRAME) ? {1'b0, len_r} : 16'h0;
    sum = base + {12'h0, cnt};
    len_nxt = (sum > LEN_SAT) ? LEN_SAT[14:0] : sum[14:0]; // [RULE13]
    err_n = ((st_r == ST_FRAME) && err_r) || rx_in_line_err;
    pos = 16'h0;
    // start from the stored header
    for (int h = 0; h < HDR_BYTES; h++) begin
      hdr_n[h] = hdr_r[h];
    end
    // overlay the lanes of this beat that fall in the header
    for (int i = 0; i < KEEP_W; i++) begin
      pos = base + 16'(i);
      if (rx_in_keep[i] && pos < 16'(HDR_BYTES)) begin
        hdr_n[pos[3:0]] = rx_in_data[i*8 +: 8];
      end
    end
  end

  // frame tracking state and accumulators
  // the frame counter wraps; software reads it as a free-running count
  // header bytes are cleared on reset only; each frame overwrites them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      len_r <= 15'h0;
      err_r <= 1'b0;
      frame_cnt_r <= 16'h0;
      for (int h = 0; h < HDR_BYTES; h++) begin
        hdr_r[h] <= 8'h00;
      end
    end else if (beat) begin
      st_r <= rx_in_last ? ST_IDLE : ST_FRAME;
      len_r <= len_nxt;
      err_r <= err_n;
      for (int h = 0; h < HDR_BYTES; h++) begin
        hdr_r[h] <= hdr_n[h];
      end
      // frames counted as their final beats are taken
      if (rx_in_last) begin
        frame_cnt_r <= frame_cnt_r + 16'h1;
      end
    end
  end

  // classification of the frame ending on this beat
  // fields look at the header including this beat, so short frames work
  // a length-field mismatch alone does not mark the frame bad
  always_comb begin
    da = {hdr_n[0], hdr_n[1], hdr_n[2], hdr_n[3], hdr_n[4], hdr_n[5]};
    lt = {hdr_n[12], hdr_n[13]};
    opc = {hdr_n[14], hdr_n[15]};
    data_bytes = (len_nxt >= OVERHEAD_BYTES) ? len_nxt - OVERHEAD_BYTES : 15'h0;
    bcast = (da == BCAST_ADDR);
    ctl = (lt == CTRL_TYPE);
    da_ok = (da == CTRL_MCAST) || (da == own_addr_r);
    pad_case = (lt < MIN_PAYLOAD);
    len_differs = ({1'b0, data_bytes} != lt);
    len_bad = (lt < TYPE_MIN) && (pad_case ? (len_nxt != MIN_FRAME) : len_differs); // [RULE6]
    oversize = !ctrl_r[CTRL_JUMBO_EN] && (len_nxt > max_len_r); // [RULE11]
    fcs_bad = rx_in_fcs_bad || err_n; // [RULE16]
    bad = fcs_bad || oversize || (len_nxt < MIN_FRAME); // [RULE17]
    good = !bad; // [RULE18] [RULE20]
    // report bits in their vector positions
    fin_vec = '0;
    fin_vec[V_PFC] = PFC_EN && good && ctl && da_ok && (opc == OP_PFC) && ctrl_r[CTRL_PAUSE_EN]; // [RULE5]
    fin_vec[V_LEN_MISMATCH] = len_bad;
    fin_vec[V_BAD_OPCODE] = good && ctl && (opc != OP_PAUSE) && !(PFC_EN && opc == OP_PFC); // [RULE7]
    fin_vec[V_PAUSE] = good && ctl && da_ok && (opc == OP_PAUSE) && ctrl_r[CTRL_PAUSE_EN]; // [RULE8]
    fin_vec[V_VLAN] = ctrl_r[CTRL_VLAN_EN] && (lt == VLAN_TYPE); // [RULE10]
    fin_vec[V_OVERSIZE] = oversize;
    fin_vec[V_CONTROL] = ctl; // [RULE12]
    fin_vec[V_LEN_HI:V_LEN_LO] = len_nxt;
    fin_vec[V_MCAST] = da[40] && !bcast; // [RULE14]
    fin_vec[V_BCAST] = bcast; // [RULE15]
    fin_vec[V_FCS] = fcs_bad;
    fin_vec[V_BAD] = bad;
    fin_vec[V_GOOD] = good;
  end

  // report vector: frame fields at frame end, byte count every cycle
  // byte count tracks the stream every cycle, the rest only at frame end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vec_r <= '0;
    end else if (ce) begin
      vec_r[V_BYTES_HI:V_BYTES_LO] <= rx_in_valid ? cnt : 4'h0; // [RULE9] [RULE2]
      // frame fields load only at the final beat
      if (fin) begin
        vec_r[V_PFC:V_BYTES_HI+1] <= fin_vec[V_PFC:V_BYTES_HI+1]; // [RULE1]
        vec_r[V_BYTES_LO-1:0] <= fin_vec[V_BYTES_LO-1:0];
      end
    end
  end

  // report strobe timing against the final beat on the client stream
  // wide datapath: strobe with the registered final beat
  // narrow datapath: one extra stage so the strobe follows it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      valid_r <= 1'b0;
      pend_r <= 1'b0;
    end else if (ce) begin
      pend_r <= fin;
      if (NARROW) begin
        valid_r <= pend_r; // [RULE4] [RULE21]
      end else begin
        valid_r <= fin; // [RULE3] [RULE21]
      end
    end
  end

  // client stream, one register stage
  // stream delayed one cycle, lining up with the report strobe on the 64-bit datapath only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
      out_keep_r <= '0;
      out_last_r <= 1'b0;
    end else if (ce) begin
      out_valid_r <= rx_in_valid;
      out_data_r <= rx_in_data;
      out_keep_r <= rx_in_keep;
      out_last_r <= rx_in_valid && rx_in_last;
    end
  end

  // every output comes straight from a flop
  // no logic between the registers and the ports
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign rx_out_valid = out_valid_r;
  assign rx_out_data = out_data_r;
  assign rx_out_keep = out_keep_r;
  assign rx_out_last = out_last_r;
  assign stat_vector = vec_r;
  assign stat_valid = valid_r;
  assign mdio_out = mdio_out_r;
  assign mdio_tri = mdio_tri_r;
endmodule

// file: rtl/rxstat_pkg.sv
// rxstat_pkg: constants for the receive frame statistics reporter.
// assumes word-addressed Avalon-MM register access and 8-bit byte lanes.
package rxstat_pkg;
  // register word indices (byte address = 4 * index)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_MAX_LEN = 3'h1;
  localparam logic [2:0] REG_OWN_LO = 3'h2;
  localparam logic [2:0] REG_OWN_HI = 3'h3;
  localparam logic [2:0] REG_LAST_VEC = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam int ADDR_W = 3;
  // control register bit positions
  localparam int CTRL_VLAN_EN = 0;
  localparam int CTRL_JUMBO_EN = 1;
  localparam int CTRL_PAUSE_EN = 2;
  localparam int CTRL_MDIO_DRV = 3;
  localparam int CTRL_MDIO_VAL = 4;
  localparam int CTRL_W = 5;
  localparam int STATUS_MDIO_IN = 31;
  // reset values
  localparam logic [4:0] CTRL_RESET = 5'h04;
  localparam logic [14:0] MAX_LEN_RESET = 15'h05EE;
  localparam logic [47:0] OWN_ADDR_RESET = 48'h000000000000;
  // report vector layout
  localparam int VEC_W = 31;
  localparam int V_PFC = 30;
  localparam int V_LEN_MISMATCH = 29;
  localparam int V_BAD_OPCODE = 28;
  localparam int V_PAUSE = 27;
  localparam int V_BYTES_LO = 23;
  localparam int V_BYTES_HI = 26;
  localparam int V_VLAN = 22;
  localparam int V_OVERSIZE = 21;
  localparam int V_CONTROL = 20;
  localparam int V_LEN_LO = 5;
  localparam int V_LEN_HI = 19;
  localparam int V_MCAST = 4;
  localparam int V_BCAST = 3;
  localparam int V_FCS = 2;
  localparam int V_BAD = 1;
  localparam int V_GOOD = 0;
  // frame constants
  localparam int HDR_BYTES = 16;
  localparam logic [15:0] LEN_SAT = 16'h7FFF;
  localparam logic [14:0] MIN_FRAME = 15'h0040;
  localparam logic [14:0] OVERHEAD_BYTES = 15'h0012;
  localparam logic [15:0] MIN_PAYLOAD = 16'h002E;
  localparam logic [15:0] TYPE_MIN = 16'h0600;
  localparam logic [15:0] CTRL_TYPE = 16'h8808;
  localparam logic [15:0] VLAN_TYPE = 16'h8100;
  localparam logic [15:0] OP_PAUSE = 16'h0001;
  localparam logic [15:0] OP_PFC = 16'h0101;
  localparam logic [47:0] CTRL_MCAST = 48'h0180C2000001;
  localparam logic [47:0] BCAST_ADDR = 48'hFFFFFFFFFFFF;
  // frame tracking states
  typedef enum logic {ST_IDLE = 1'b0, ST_FRAME = 1'b1} rx_state_t;
endpackage

// file: verification/rxstat_chk.sv
// rxstat_chk: concurrent checks on the receive report ports.
// assumes one clock, ce held high by the bench, bound into the reporter.
`timescale 1ns/100ps
module rxstat_chk #(
  parameter int DATA_W = 64
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_in_valid,
  input wire logic [DATA_W/8-1:0] rx_in_keep,
  input wire logic rx_in_last,
  input wire logic rx_in_fcs_bad,
  input wire logic [rxstat_pkg::VEC_W-1:0] stat_vector,
  input wire logic stat_valid
);
  import rxstat_pkg::*;
  localparam int LAT = (DATA_W == 64) ? 1 : 2;
  logic [3:0] lanes_r;
  // lanes taken at the previous edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lanes_r <= 4'h0;
    end else begin
      lanes_r <= rx_in_valid ? 4'($countones(rx_in_keep)) : 4'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  strobe_one_a: assert property (stat_valid |=> !stat_valid)
    else $error("report strobe longer than one cycle");
  strobe_time_a: assert property (rx_in_valid && rx_in_last |-> ##LAT stat_valid)
    else $error("report strobe late");
  good_xor_a: assert property (stat_valid |-> stat_vector[V_GOOD] != stat_vector[V_BAD])
    else $error("good and bad flags disagree");
  lane_count_a: assert property (stat_vector[V_BYTES_HI:V_BYTES_LO] == lanes_r)
    else $error("byte count wrong");
  fields_hold_a: assert property (!stat_valid && !$past(rx_in_valid && rx_in_last) |-> $stable({stat_vector[30:27], stat_vector[22:0]}))
    else $error("report changed outside strobe");
  fcs_flag_a: assert property (rx_in_valid && rx_in_last && rx_in_fcs_bad |-> ##LAT stat_vector[V_FCS] && stat_vector[V_BAD])
    else $error("fcs error not reported");
  pause_good_a: assert property (stat_valid && stat_vector[V_PAUSE] |-> stat_vector[V_CONTROL] && stat_vector[V_GOOD])
    else $error("pause flag on bad or non control frame");
  opcode_good_a: assert property (stat_valid && stat_vector[V_BAD_OPCODE] |-> stat_vector[V_GOOD] && !stat_vector[V_PAUSE])
    else $error("bad opcode flag inconsistent");
  pfc_ctrl_a: assert property (stat_valid && stat_vector[V_PFC] |-> stat_vector[V_CONTROL] && stat_vector[V_GOOD])
    else $error("priority pause flag inconsistent");
  // main scenarios reached
  cover property (stat_valid && stat_vector[V_PAUSE]);
  cover property (stat_valid && stat_vector[V_BAD]);
  cover property (stat_valid && stat_vector[V_LEN_MISMATCH]);
  cover property (stat_valid && stat_vector[V_PFC]);
endmodule
bind rx_frame_statistics_vector rxstat_chk #(.DATA_W(DATA_W)) u_chk (.clk(clk), .rst_b(rst_b),
  .rx_in_valid(rx_in_valid), .rx_in_keep(rx_in_keep), .rx_in_last(rx_in_last), .rx_in_fcs_bad(rx_in_fcs_bad),
  .stat_vector(stat_vector), .stat_valid(stat_valid));

// file: verification/report_sink.sv
// report_sink: client logic taking per-frame receive reports.
// assumes reports arrive on clk, one strobe per frame.
`timescale 1ns/100ps
module report_sink (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stat_valid,
  input wire logic [rxstat_pkg::VEC_W-1:0] stat_vector,
  output logic [rxstat_pkg::VEC_W-1:0] last_rep,
  output int n_rep
);
  import rxstat_pkg::*;
  // take the report only in its strobe cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      last_rep <= '0;
      n_rep <= 0;
    end else if (stat_valid === 1'b1) begin
      last_rep <= stat_vector;
      n_rep <= n_rep + 1;
    end
  end
endmodule

// file: verification/testbench.sv
// testbench: frames and register accesses against the receive reporter.
// assumes 64-bit datapath with priority pause built in.
`timescale 1ns/100ps
module testbench;
  import rxstat_pkg::*;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest, rx_in_valid, rx_in_last, rx_in_line_err;
  logic rx_in_fcs_bad, mdio_in, mdio_out, mdio_tri, stat_valid;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [63:0] rx_in_data;
  logic [7:0] rx_in_keep;
  logic [VEC_W-1:0] stat_vector, last_rep;
  logic [7:0] fr[$];
  logic [4:0] ctl;
  logic [47:0] da, own;
  logic [15:0] ty;
  int n_rep, n_errors, tests_run, mx, k, n, t, nf;
  int cyc = 0;
  localparam logic [30:0] MASK = 31'h787FFFFF;
  rx_frame_statistics_vector #(.DATA_W(64), .PFC_EN(1'b1)) u_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data), .rx_in_keep(rx_in_keep), .rx_in_last(rx_in_last),
    .rx_in_line_err(rx_in_line_err), .rx_in_fcs_bad(rx_in_fcs_bad), .rx_out_valid(), .rx_out_data(),
    .rx_out_keep(), .rx_out_last(), .stat_vector(stat_vector), .stat_valid(stat_valid),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_tri(mdio_tri));
  report_sink u_sink (.clk(clk), .rst_b(rst_b), .stat_valid(stat_valid), .stat_vector(stat_vector),
    .last_rep(last_rep), .n_rep(n_rep));
  // clock and hang limit
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up();
    end
  end
  // expected report from frame contents and settings
  function automatic logic [30:0] exp_v(int len, logic [47:0] a, logic [15:0] y, logic [15:0] op, logic fb, logic le);
    logic [30:0] v;
    logic c, p, e, o;
    v = '0;
    o = !ctl[1] && len > mx;
    e = fb | le | o | (len < 64);
    c = (y == CTRL_TYPE);
    p = !e && c && ctl[2] && (a == CTRL_MCAST || a == own);
    v[V_FCS] = fb | le;
    v[V_BAD] = e;
    v[V_GOOD] = !e;
    v[V_OVERSIZE] = o;
    v[V_CONTROL] = c;
    v[V_VLAN] = (y == VLAN_TYPE) && ctl[0];
    v[V_BCAST] = (a == BCAST_ADDR);
    v[V_MCAST] = a[40] && !v[V_BCAST];
    v[V_LEN_HI:V_LEN_LO] = (len > 32767) ? 15'h7FFF : 15'(len);
    v[V_PAUSE] = p && op == OP_PAUSE;
    v[V_PFC] = p && op == OP_PFC;
    v[V_BAD_OPCODE] = !e && c && op != OP_PAUSE && op != OP_PFC;
    v[V_LEN_MISMATCH] = y < TYPE_MIN && ((y < MIN_PAYLOAD) ? len != 64 : int'(y) != len - 18);
    return v;
  endfunction
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one Avalon transfer, held until waitrequest is seen low
  task av(logic we, logic [2:0] a, logic [31:0] d);
    @(posedge clk);
    avs_write <= we;
    avs_read <= !we;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wc(logic [4:0] c);
    ctl = c;
    av(1'b1, REG_CTRL, {27'h0, c});
  endtask
  // send one frame as 8-byte beats, then compare the report
  task frm(int len, logic [47:0] a, logic [15:0] y, logic [15:0] op, logic fb, logic le);
    int i, j, n0;
    logic [63:0] d;
    logic [7:0] kp;
    fr = {};
    for (i = 0; i < len; i++) fr.push_back(8'($urandom));
    for (i = 0; i < 6; i++) fr[i] = a[47-8*i -: 8];
    {fr[12], fr[13], fr[14], fr[15]} = {y, op};
    n0 = n_rep;
    nf++;
    for (i = 0; i < len; i += 8) begin
      d = ~rx_in_data;
      kp = 8'h00;
      for (j = 0; j < 8 && i + j < len; j++) begin
        d[8*j +: 8] = fr[i+j];
        kp[j] = 1'b1;
      end
      @(posedge clk);
      rx_in_valid <= 1'b1;
      rx_in_data <= d;
      rx_in_keep <= kp;
      rx_in_last <= (i + 8 >= len);
      rx_in_fcs_bad <= fb;
      rx_in_line_err <= le;
    end
    @(posedge clk);
    {rx_in_valid, rx_in_last, rx_in_fcs_bad, rx_in_line_err, rx_in_keep} <= '0;
    rx_in_data <= ~d;
    for (i = 0; i < 8 && n_rep == n0; i++) @(posedge clk);
    @(posedge clk);
    chk("vector", {1'b0, MASK & exp_v(len, a, y, op, fb, le)}, {1'b0, MASK & last_rep});
    chk("reports", n0 + 1, n_rep);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence: registers, corner frames, random frames
  initial begin
    {rst_b, avs_read, avs_write, avs_address, avs_writedata, rx_in_valid, rx_in_data} = '0;
    {rx_in_keep, rx_in_last, rx_in_line_err, rx_in_fcs_bad, mdio_in, n_errors, tests_run, nf} = '0;
    ctl = CTRL_RESET;
    mx = 1518;
    da = 48'h02A1B2C3D4E5;
    own = OWN_ADDR_RESET;
    k = $urandom(32'hEDE2A2F8);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    av(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", {27'h0, CTRL_RESET}, rd);
    av(1'b0, 3'h6, 32'h0);
    chk("unmapped", 32'h0, rd);
    wc(5'h0C);
    repeat (2) @(posedge clk);
    chk("tri", 32'h0, {31'h0, mdio_tri});
    chk("mdo", 32'h0, {31'h0, mdio_out});
    wc(5'h14);
    repeat (2) @(posedge clk);
    chk("tri", 32'h1, {31'h0, mdio_tri});
    chk("mdo", 32'h1, {31'h0, mdio_out});
    frm(64, CTRL_MCAST, CTRL_TYPE, OP_PAUSE, 1'b0, 1'b0);
    frm(64, CTRL_MCAST, CTRL_TYPE, OP_PFC, 1'b0, 1'b0);
    frm(64, BCAST_ADDR, CTRL_TYPE, 16'h0002, 1'b0, 1'b0);
    frm(80, da, 16'd62, 16'h0, 1'b0, 1'b0);
    frm(80, da, 16'd50, 16'h0, 1'b0, 1'b0);
    frm(70, da, 16'd20, 16'h0, 1'b0, 1'b0);
    frm(64, da, 16'd20, 16'h0, 1'b0, 1'b0);
    frm(72, 48'h0300AABBCCDD, VLAN_TYPE, 16'h0, 1'b0, 1'b0);
    wc(5'h05);
    frm(72, da, VLAN_TYPE, 16'h0, 1'b0, 1'b0);
    av(1'b1, REG_OWN_LO, da[31:0]);
    av(1'b1, REG_OWN_HI, {16'h0, da[47:32]});
    own = da;
    frm(64, da, CTRL_TYPE, OP_PAUSE, 1'b0, 1'b0);
    frm(64, da, 16'h0800, 16'h0, 1'b1, 1'b0);
    frm(64, da, 16'h0800, 16'h0, 1'b0, 1'b1);
    frm(60, da, 16'h0800, 16'h0, 1'b0, 1'b0);
    av(1'b1, REG_MAX_LEN, 32'd100);
    mx = 100;
    frm(101, da, 16'h0800, 16'h0, 1'b0, 1'b0);
    frm(100, da, 16'h0800, 16'h0, 1'b0, 1'b0);
    wc(5'h02);
    frm(101, CTRL_MCAST, CTRL_TYPE, OP_PAUSE, 1'b0, 1'b0);
    frm(33000, da, 16'h0800, 16'h0, 1'b0, 1'b0);
    av(1'b0, REG_LAST_VEC, 32'h0);
    chk("lastvec", {1'b0, MASK & exp_v(33000, da, 16'h0800, 16'h0, 1'b0, 1'b0)}, {1'b0, MASK & rd[30:0]});
    mdio_in <= 1'b1;
    repeat (3) @(posedge clk);
    av(1'b0, REG_STATUS, 32'h0);
    chk("status", {1'b1, 15'h0, 16'(nf)}, rd);
    for (k = 0; k < 24; k++) begin
      wc(5'($urandom % 8));
      n = 64 + $urandom % 120;
      t = $urandom % 4;
      ty = (t == 0) ? 16'h0800 : (t == 1) ? CTRL_TYPE : (t == 2) ? VLAN_TYPE : 16'(n - 18);
      frm(n, {7'h01, 1'($urandom), 40'($urandom)}, ty, ($urandom % 2) ? OP_PAUSE : 16'h0003,
        ($urandom % 6) == 0, 1'b0);
    end
    wrap_up();
  end
endmodule
